/* File: rtl/gsc_pkg.sv */
// Purpose: Shared constants and types of the global status and control register block.
// Assumes: 32-bit Avalon-MM data, byte addresses, 16-bit register in the low half.
// Notes:   Overview of operation
// Overview of operation
// - Sticky access fault flag in bit 7.
// - Fault on invalid, forbidden access or early mode clear.
// - Bit 3 reports the shutdown request.
// - Shutdown request clears on next register access.
// - Bit 2 reports time stamp counter running.
// - Mode 0: channels reset, channel access faults.
// - Mode 1: channel access allowed, temp buffer faults.
// - Mode clears only when all channels idle.
// - Mode 0: buffer search setup write gives wrong result.
// - Bits 11/3 set/clear the shutdown request.
// - Bits 10/2 set/clear the time stamp run bit.
// - Bits 8/0 set/clear-request the operation mode.
// - Writing 1 to bit 7 clears fault flag.
// - Register written only as a whole 16-bit word.
package gsc_pkg;

    // Bus geometry.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int BE_W   = 4;
    localparam int REG_W  = 16;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_GLOBAL_STATUS_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CHANNEL_VIEW          = 4'h4;

    // Byte lanes that carry the 16-bit register.
    localparam logic [BE_W-1:0] BE_LOW_HALF = 4'h3;

    // Read field positions.
    localparam int BIT_MODE      = 0;
    localparam int BIT_TS_RUN    = 2;
    localparam int BIT_SHUTDOWN  = 3;
    localparam int BIT_FAULT     = 7;
    localparam int BIT_FIXED_ONE = 8;

    // Write set positions; clear positions share the read positions.
    localparam int BIT_SET_MODE     = 8;
    localparam int BIT_SET_TS_RUN   = 10;
    localparam int BIT_SET_SHUTDOWN = 11;

    // Reset values.
    localparam logic RST_MODE     = 1'b0;
    localparam logic RST_TS_RUN   = 1'b0;
    localparam logic RST_SHUTDOWN = 1'b0;
    localparam logic RST_FAULT    = 1'b0;
    localparam logic [DATA_W-1:0] RST_READDATA = 32'h0000_0000;

    // Region targeted by an access of the memory access controller.
    typedef enum logic [1:0] {
        REGION_CHANNEL  = 2'b00,
        REGION_TEMP_BUF = 2'b01,
        REGION_MSG_BUF  = 2'b10,
        REGION_INVALID  = 2'b11
    } region_type;

    // Bus slave states.
    typedef enum logic {
        BUS_IDLE   = 1'b0,
        BUS_ANSWER = 1'b1
    } bus_state_type;

endpackage

/* File: rtl/gsc_check_if.sv */
`timescale 1ns/1ns
// Purpose: Carries the access check between the register block and its checker.
// Assumes: Same clock on both sides.
// Notes:   Purely combinational connection.
interface gsc_check_if;
    logic                   mode;         // Current global operation mode.
    logic                   access_valid; // Access controller access this cycle.
    gsc_pkg::region_type    region;       // Region that the access targets.
    logic                   search_wr;    // Write to the buffer search setup register.
    logic                   fault;        // The access is refused.
    logic                   search_bad;   // The search setup write corrupts results.

    modport owner   (output mode, output access_valid, output region, output search_wr,
                     input fault, input search_bad);
    modport judge   (input mode, input access_valid, input region, input search_wr,
                     output fault, output search_bad);
endinterface

/* File: rtl/gsc_access_check.sv */
`timescale 1ns/1ns
// Purpose: Decides whether an access controller access is allowed in the current mode.
// Assumes: Inputs are stable within the cycle.
// Notes:   Combinational only; the owner registers the result.
module gsc_access_check (
    // Check request and answer.
    gsc_check_if.judge chk
);

    // Region permission decode for the current mode.
    always_comb begin
        chk.fault = 1'b0;
        if (chk.access_valid) begin
            case (chk.region)
                // Channel registers are open only in operating mode.
                gsc_pkg::REGION_CHANNEL:  chk.fault = ~chk.mode;
                // The temporary buffer is open only outside operating mode.
                gsc_pkg::REGION_TEMP_BUF: chk.fault = chk.mode;
                // The message buffer area is always open.
                gsc_pkg::REGION_MSG_BUF:  chk.fault = 1'b0;
                // An invalid address is always refused.
                gsc_pkg::REGION_INVALID:  chk.fault = 1'b1;
                default:                  chk.fault = 1'b1;
            endcase
        end
    end

    // A search setup write outside operating mode spoils the search result.
    always_comb begin
        chk.search_bad = chk.search_wr & ~chk.mode;
    end

endmodule

/* File: rtl/can_global_status_control.sv */
`timescale 1ns/1ns
// Purpose: Global status and control register with its Avalon-MM slave port.
// Assumes: Channel status and access reports come from logic on clk_sys_in.
// Notes:   Each access takes one wait cycle; effects land when waitrequest is low.
module can_global_status_control #(
    parameter int N_CHANNELS = 1
) (
    // Clock and reset.
    input  wire logic                         clk_sys_in,
    input  wire logic                         arst_n_in,
    // Avalon-MM slave.
    input  wire logic [gsc_pkg::ADDR_W-1:0]   address_in,
    input  wire logic                         read_in,
    input  wire logic                         write_in,
    input  wire logic [gsc_pkg::DATA_W-1:0]   writedata_in,
    input  wire logic [gsc_pkg::BE_W-1:0]     byteenable_in,
    output logic      [gsc_pkg::DATA_W-1:0]   readdata_out,
    output logic                              waitrequest_out,
    // Access controller reports.
    input  wire logic                         mem_access_valid_in,
    input  wire gsc_pkg::region_type          mem_access_region_in,
    input  wire logic                         search_setup_write_in,
    // Channel status.
    input  wire logic [N_CHANNELS-1:0]        channel_idle_status_in,
    input  wire logic [N_CHANNELS-1:0]        channel_halt_request_in,
    // Control outputs.
    output logic                              global_operation_mode_out,
    output logic      [N_CHANNELS-1:0]        channel_reset_out,
    output logic                              timestamp_run_out,
    output logic                              shutdown_request_out,
    output logic                              access_fault_flag_out,
    output logic                              access_fault_event_out,
    output logic                              access_refused_out,
    output logic                              search_result_bad_out
);

    // Bus slave state.
    gsc_pkg::bus_state_type          bus_state_reg;     // Current bus state.
    gsc_pkg::bus_state_type          bus_state_next;    // Next bus state.
    logic                            wait_reg;          // Registered waitrequest.
    logic                            wait_next;         // Next waitrequest.
    logic [gsc_pkg::DATA_W-1:0]      readdata_reg;      // Registered read data.
    logic [gsc_pkg::DATA_W-1:0]      readdata_next;     // Next read data.

    // Register contents.
    logic                            mode_reg;          // Global operation mode.
    logic                            mode_next;         // Next mode.
    logic                            ts_run_reg;        // Time stamp counter run.
    logic                            ts_run_next;       // Next run bit.
    logic                            shutdown_reg;      // Shutdown request.
    logic                            shutdown_next;     // Next shutdown request.
    logic                            fault_reg;         // Sticky access fault.
    logic                            fault_next;        // Next fault flag.

    // Registered side outputs.
    logic                            event_reg;         // Fault event pulse.
    logic                            event_next;        // Next fault event.
    logic                            refused_reg;       // Access refused pulse.
    logic                            refused_next;      // Next refused pulse.
    logic                            search_bad_reg;    // Bad search result flag.
    logic                            search_bad_next;   // Next bad search flag.
    logic [N_CHANNELS-1:0]           chan_rst_reg;      // Channel reset lines.
    logic [N_CHANNELS-1:0]           chan_rst_next;     // Next channel reset lines.

    // Decoded bus terms.
    logic                            request;           // A read or write is pending.
    logic                            complete;          // This edge finishes the access.
    logic                            hit_gsc;           // Access targets the main register.
    logic                            hit_view;          // Access targets the channel view.
    logic                            full_word;         // Both low byte lanes enabled.
    logic                            do_write;          // Write to main register takes effect.
    logic                            bus_unmapped;      // Access to no register.
    logic [gsc_pkg::REG_W-1:0]       wdata;             // Low half of the write data.
    logic                            mode_clear_req;    // Software asks for mode clear.
    logic                            mode_clear_early;  // Mode clear without halted channels.
    logic                            fault_event;       // Any fault source this cycle.

    // Checker connection.
    gsc_check_if chk_if ();

    // Compares a set/clear pair; returns 1 when only the set bit is high.
    function automatic logic pair_set(input logic set_bit, input logic clr_bit);
        pair_set = set_bit & ~clr_bit;
    endfunction

    // Compares a set/clear pair; returns 1 when only the clear bit is high.
    function automatic logic pair_clear(input logic set_bit, input logic clr_bit);
        pair_clear = ~set_bit & clr_bit;
    endfunction

    // Checks whether a byte address hits a given register offset.
    function automatic logic addr_hit(input logic [gsc_pkg::ADDR_W-1:0] addr,
                                      input logic [gsc_pkg::ADDR_W-1:0] ofs);
        addr_hit = (addr == ofs);
    endfunction

    // Access permission checker.
    gsc_access_check u_check (
        .chk (chk_if.judge)
    );

    // Feed the checker with the current mode and the reported access.
    always_comb begin
        chk_if.mode         = mode_reg;
        chk_if.access_valid = mem_access_valid_in;
        chk_if.region       = mem_access_region_in;
        chk_if.search_wr    = search_setup_write_in;
    end

    // Bus decode shared by the bus state and the register update.
    always_comb begin
        request      = read_in | write_in;
        complete     = request & (bus_state_reg == gsc_pkg::BUS_ANSWER);
        hit_gsc      = addr_hit(address_in, gsc_pkg::OFS_GLOBAL_STATUS_CONTROL);
        hit_view     = addr_hit(address_in, gsc_pkg::OFS_CHANNEL_VIEW);
        // Byte or partial writes are dropped.
        full_word    = (byteenable_in[1:0] == gsc_pkg::BE_LOW_HALF[1:0]);
        do_write     = complete & write_in & hit_gsc & full_word;
        bus_unmapped = complete & ~hit_gsc & ~hit_view;
        wdata        = writedata_in[gsc_pkg::REG_W-1:0];
    end

    // Next bus state: one wait cycle, then the answer cycle with waitrequest low.
    always_comb begin
        bus_state_next = bus_state_reg;
        wait_next      = 1'b1;
        readdata_next  = readdata_reg;
        case (bus_state_reg)
            gsc_pkg::BUS_IDLE: begin
                if (request) begin
                    // Load the answer now so it stands during the answer cycle.
                    bus_state_next = gsc_pkg::BUS_ANSWER;
                    wait_next      = 1'b0;
                    readdata_next  = gsc_pkg::RST_READDATA;
                    if (hit_gsc) begin
                        readdata_next[gsc_pkg::BIT_MODE]      = mode_reg;
                        readdata_next[gsc_pkg::BIT_TS_RUN]    = ts_run_reg;
                        readdata_next[gsc_pkg::BIT_SHUTDOWN]  = shutdown_reg;
                        readdata_next[gsc_pkg::BIT_FAULT]     = fault_reg;
                        readdata_next[gsc_pkg::BIT_FIXED_ONE] = 1'b1;
                    end else if (hit_view) begin
                        // Channel view: idle status low, halt requests above.
                        readdata_next[N_CHANNELS-1:0] = channel_idle_status_in;
                        readdata_next[gsc_pkg::REG_W+N_CHANNELS-1:gsc_pkg::REG_W] =
                            channel_halt_request_in;
                    end
                end
            end
            gsc_pkg::BUS_ANSWER: begin
                // The master takes the answer at this edge and releases.
                bus_state_next = gsc_pkg::BUS_IDLE;
                wait_next      = 1'b1;
            end
            default: begin
                bus_state_next = gsc_pkg::BUS_IDLE;
                wait_next      = 1'b1;
            end
        endcase
    end

    // Register the bus state.
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bus_state_reg <= gsc_pkg::BUS_IDLE;
            wait_reg      <= 1'b1;
            readdata_reg  <= gsc_pkg::RST_READDATA;
        end else begin
            bus_state_reg <= bus_state_next;
            wait_reg      <= wait_next;
            readdata_reg  <= readdata_next;
        end
    end

    // Mode clear request and its premature form.
    always_comb begin
        mode_clear_req   = do_write & pair_clear(wdata[gsc_pkg::BIT_SET_MODE],
                                                 wdata[gsc_pkg::BIT_MODE]);
        // Clearing mode while any channel lacks its halt request is a fault.
        mode_clear_early = mode_clear_req & mode_reg &
                           ~(&channel_halt_request_in);
    end

    // Next values of the register bits.
    always_comb begin
        mode_next     = mode_reg;
        ts_run_next   = ts_run_reg;
        shutdown_next = shutdown_reg;
        fault_next    = fault_reg;

        // Any completed access of the register retires a pending shutdown request.
        if (complete & hit_gsc & shutdown_reg) begin
            shutdown_next = 1'b0;
        end

        if (do_write) begin
            // Shutdown request pair.
            if (pair_set(wdata[gsc_pkg::BIT_SET_SHUTDOWN], wdata[gsc_pkg::BIT_SHUTDOWN])) begin
                shutdown_next = 1'b1;
            end else if (pair_clear(wdata[gsc_pkg::BIT_SET_SHUTDOWN],
                                    wdata[gsc_pkg::BIT_SHUTDOWN])) begin
                shutdown_next = 1'b0;
            end
            // Time stamp run pair.
            if (pair_set(wdata[gsc_pkg::BIT_SET_TS_RUN], wdata[gsc_pkg::BIT_TS_RUN])) begin
                ts_run_next = 1'b1;
            end else if (pair_clear(wdata[gsc_pkg::BIT_SET_TS_RUN],
                                    wdata[gsc_pkg::BIT_TS_RUN])) begin
                ts_run_next = 1'b0;
            end
            // Mode pair; a set is taken at once.
            if (pair_set(wdata[gsc_pkg::BIT_SET_MODE], wdata[gsc_pkg::BIT_MODE])) begin
                mode_next = 1'b1;
            end
            // Writing 1 to the fault position clears the flag.
            if (wdata[gsc_pkg::BIT_FAULT]) begin
                fault_next = 1'b0;
            end
        end

        // A clear is honoured only after a shutdown request from an earlier access
        // and only with every channel idle; otherwise mode stays set.
        if (mode_clear_req & shutdown_reg & (&channel_idle_status_in)) begin
            mode_next = 1'b0;
        end

        // A new fault wins over a simultaneous software clear.
        if (fault_event) begin
            fault_next = 1'b1;
        end
    end

    // Collect the fault sources.
    always_comb begin
        fault_event = chk_if.fault | mode_clear_early | bus_unmapped;
    end

    // Register the status bits.
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mode_reg     <= gsc_pkg::RST_MODE;
            ts_run_reg   <= gsc_pkg::RST_TS_RUN;
            shutdown_reg <= gsc_pkg::RST_SHUTDOWN;
            fault_reg    <= gsc_pkg::RST_FAULT;
        end else begin
            mode_reg     <= mode_next;
            ts_run_reg   <= ts_run_next;
            shutdown_reg <= shutdown_next;
            fault_reg    <= fault_next;
        end
    end

    // Next values of the side outputs.
    always_comb begin
        // One pulse for each cycle in which a fault is recorded.
        event_next      = fault_event;
        refused_next    = chk_if.fault;
        // Sticky until operating mode is entered, as the search result is stale.
        search_bad_next = search_bad_reg;
        if (chk_if.search_bad) begin
            search_bad_next = 1'b1;
        end else if (mode_reg) begin
            search_bad_next = 1'b0;
        end
        // Channels are held in reset while mode is clear.
        chan_rst_next   = {N_CHANNELS{~mode_next}};
    end

    // Register the side outputs.
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            event_reg      <= 1'b0;
            refused_reg    <= 1'b0;
            search_bad_reg <= 1'b0;
            chan_rst_reg   <= {N_CHANNELS{1'b1}};
        end else begin
            event_reg      <= event_next;
            refused_reg    <= refused_next;
            search_bad_reg <= search_bad_next;
            chan_rst_reg   <= chan_rst_next;
        end
    end

    // Drive the ports straight from flip-flops.
    assign readdata_out              = readdata_reg;
    assign waitrequest_out           = wait_reg;
    assign global_operation_mode_out = mode_reg;
    assign channel_reset_out         = chan_rst_reg;
    assign timestamp_run_out         = ts_run_reg;
    assign shutdown_request_out      = shutdown_reg;
    assign access_fault_flag_out     = fault_reg;
    assign access_fault_event_out    = event_reg;
    assign access_refused_out        = refused_reg;
    assign search_result_bad_out     = search_bad_reg;

endmodule

/* File: verification/gsc_props.sv */
// Purpose: Concurrent checks on the ports of the global status and control register block.
// Assumes: One clock domain, asynchronous active-low reset, one wait cycle per bus access.
// Notes:   Bound to every instance of the block after the module.
`timescale 1ns/1ns
module gsc_props #(
    parameter int N_CHANNELS = 1
) (
    // Clock, reset and register bus.
    input wire logic                       clk_sys_in,
    input wire logic                       arst_n_in,
    input wire logic [gsc_pkg::ADDR_W-1:0] address_in,
    input wire logic                       read_in,
    input wire logic                       write_in,
    input wire logic [gsc_pkg::DATA_W-1:0] writedata_in,
    input wire logic [gsc_pkg::BE_W-1:0]   byteenable_in,
    input wire logic [gsc_pkg::DATA_W-1:0] readdata_out,
    input wire logic                       waitrequest_out,
    // Access controller reports and channel status.
    input wire logic                       mem_access_valid_in,
    input wire gsc_pkg::region_type        mem_access_region_in,
    input wire logic                       search_setup_write_in,
    input wire logic [N_CHANNELS-1:0]      channel_idle_status_in,
    // Control outputs.
    input wire logic                       global_operation_mode_out,
    input wire logic [N_CHANNELS-1:0]      channel_reset_out,
    input wire logic                       timestamp_run_out,
    input wire logic                       shutdown_request_out,
    input wire logic                       access_fault_flag_out,
    input wire logic                       access_fault_event_out,
    input wire logic                       access_refused_out,
    input wire logic                       search_result_bad_out
);
    logic acc0; // A bus access to the main register completes this cycle.
    logic wr0;  // A full-word write to the main register completes this cycle.
    logic mva;  // An access controller access is reported this cycle.
    assign acc0 = (read_in || write_in) && !waitrequest_out && address_in == 4'h0;
    assign wr0  = acc0 && write_in && byteenable_in[1:0] == 2'b11;
    assign mva  = mem_access_valid_in;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);
    chk_bus_answer: assert property ((read_in || write_in) && waitrequest_out |=> !waitrequest_out)
        else $error("bus request not answered after one wait cycle");
    chk_invalid_fault: assert property (
        mva && mem_access_region_in == gsc_pkg::REGION_INVALID |=> access_fault_flag_out)
        else $error("invalid access did not set the fault flag");
    chk_rose_event: assert property (
        $rose(access_fault_flag_out) |-> access_fault_event_out)
        else $error("fault flag rose without an event pulse");
    chk_flag_clear: assert property (
        $fell(access_fault_flag_out) |-> $past(wr0 && writedata_in[7]))
        else $error("fault flag fell without a clearing write");
    chk_temp_refused: assert property (
        mva && mem_access_region_in == gsc_pkg::REGION_TEMP_BUF && global_operation_mode_out
        |=> access_refused_out && access_fault_flag_out)
        else $error("temporary buffer access accepted in operation mode");
    chk_chan_refused: assert property (
        mva && mem_access_region_in == gsc_pkg::REGION_CHANNEL && !global_operation_mode_out
        |=> access_refused_out)
        else $error("channel access accepted outside operation mode");
    chk_msg_allowed: assert property (
        mva && mem_access_region_in == gsc_pkg::REGION_MSG_BUF |=> !access_refused_out)
        else $error("message buffer access refused");
    chk_chan_reset: assert property (
        channel_reset_out == {N_CHANNELS{~global_operation_mode_out}})
        else $error("channel reset does not follow the mode bit");
    chk_mode_idle: assert property ($fell(global_operation_mode_out)
        |-> $past(&channel_idle_status_in && shutdown_request_out))
        else $error("mode cleared with a busy channel or no shutdown request");
    chk_shutdown_auto: assert property (shutdown_request_out && acc0
        && !(write_in && writedata_in[11] && !writedata_in[3]) |=> !shutdown_request_out)
        else $error("shutdown request survived a register access");
    chk_ts_set: assert property (wr0 && writedata_in[10] && !writedata_in[2]
        |=> timestamp_run_out)
        else $error("time stamp run bit not set");
    chk_partial_write: assert property (
        write_in && !waitrequest_out && byteenable_in[1:0] != 2'b11 |=> $stable(timestamp_run_out))
        else $error("partial write changed the register");
    chk_read_fields: assert property (acc0 && read_in
        |-> readdata_out[8] && readdata_out[2] == timestamp_run_out)
        else $error("read data fields wrong");
    chk_search_bad: assert property (
        search_setup_write_in && !global_operation_mode_out |=> search_result_bad_out)
        else $error("search setup write outside operation mode not flagged");
    // Main scenarios.
    cov_mode_left: cover property ($fell(global_operation_mode_out));
    cov_fault: cover property ($rose(access_fault_flag_out));
    cov_search_bad: cover property (search_result_bad_out);
endmodule
bind can_global_status_control gsc_props #(.N_CHANNELS(N_CHANNELS)) u_gsc_props (.*);

/* File: verification/testbench.sv */
// Purpose: Self-checking bench for the global status and control register block.
// Assumes: Bus tasks hold each request until waitrequest is sampled low.
// Notes:   Two channels; inputs change by non-blocking assignment at rising edges.
`timescale 1ns/1ns
module testbench;
    logic                 clk_sys_in, arst_n_in, read_in, write_in, waitrequest_out;
    logic [3:0]           address_in, byteenable_in;
    logic [31:0]          writedata_in, readdata_out, rd_word;
    logic                 mem_access_valid_in, search_setup_write_in;
    gsc_pkg::region_type  mem_access_region_in;
    logic [1:0]           channel_idle_status_in, channel_halt_request_in, channel_reset_out;
    logic                 global_operation_mode_out, timestamp_run_out, shutdown_request_out;
    logic                 access_fault_flag_out, access_fault_event_out;
    logic                 access_refused_out, search_result_bad_out;
    int                   err_count = 0;
    int                   n_tests   = 0;
    can_global_status_control #(.N_CHANNELS(2)) u_can_global_status_control (.*);
    // Clock, 5 ns half period.
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    // Compares one value and reports a mismatch at once.
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    // One Avalon-MM access, held until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        @(posedge clk_sys_in);
        write_in      <= w;
        read_in       <= ~w;
        address_in    <= a;
        writedata_in  <= d;
        byteenable_in <= be;
        do begin
            @(posedge clk_sys_in);
        end while (waitrequest_out !== 1'b0);
        rd_word = readdata_out;
        read_in  <= 1'b0;
        write_in <= 1'b0;
    endtask
    // Full-word write to and checked read of the main register.
    task automatic wr(input logic [31:0] d);
        bus(1'b1, 4'h0, d, 4'h3);
    endtask
    task automatic rd(input logic [31:0] exp);
        bus(1'b0, 4'h0, 32'h0, 4'h3);
        chk("status", exp, rd_word);
    endtask
    // One access controller report; the refusal pulse is seen two edges later.
    task automatic macc(input gsc_pkg::region_type g, input logic exp);
        @(posedge clk_sys_in);
        mem_access_valid_in  <= 1'b1;
        mem_access_region_in <= g;
        @(posedge clk_sys_in);
        mem_access_valid_in <= 1'b0;
        @(posedge clk_sys_in);
        chk("refused", {31'h0, exp}, {31'h0, access_refused_out});
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        #20000;
        err_count++;
        wrap_up();
    end
    // Main sequence.
    initial begin
        {arst_n_in, read_in, write_in, mem_access_valid_in, search_setup_write_in} = 5'h0;
        {address_in, byteenable_in, writedata_in} = 40'h0;
        mem_access_region_in = gsc_pkg::REGION_MSG_BUF;
        {channel_idle_status_in, channel_halt_request_in} = 4'h0;
        repeat (3) @(posedge clk_sys_in);
        arst_n_in <= 1'b1;
        rd(32'h100);
        wr(32'h400); rd(32'h104);
        wr(32'h404); rd(32'h104); wr(32'h4); rd(32'h100);
        bus(1'b1, 4'h0, 32'h400, 4'h1); rd(32'h100);
        wr(32'h100); rd(32'h101);
        chk("chan_reset", 32'h0, {30'h0, channel_reset_out});
        macc(gsc_pkg::REGION_TEMP_BUF, 1'b1); rd(32'h181);
        wr(32'h80); rd(32'h101);
        macc(gsc_pkg::REGION_CHANNEL, 1'b0); macc(gsc_pkg::REGION_MSG_BUF, 1'b0);
        wr(32'h1); rd(32'h181); wr(32'h80);
        channel_halt_request_in <= 2'b11;
        wr(32'h800); rd(32'h109); rd(32'h101);
        wr(32'h800); wr(32'h8); rd(32'h101);
        wr(32'h800); wr(32'h1); rd(32'h101);
        channel_idle_status_in <= 2'b11;
        wr(32'h800); wr(32'h1); rd(32'h100);
        macc(gsc_pkg::REGION_CHANNEL, 1'b1); rd(32'h180); wr(32'h80);
        macc(gsc_pkg::REGION_TEMP_BUF, 1'b0);
        macc(gsc_pkg::REGION_INVALID, 1'b1);
        wr(32'h80);
        bus(1'b0, 4'hc, 32'h0, 4'h3); chk("unmapped", 32'h0, rd_word); rd(32'h180);
        @(posedge clk_sys_in);
        search_setup_write_in <= 1'b1;
        @(posedge clk_sys_in);
        search_setup_write_in <= 1'b0;
        @(posedge clk_sys_in);
        chk("search_bad", 32'h1, {31'h0, search_result_bad_out});
        wr(32'h500); arst_n_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        arst_n_in <= 1'b1;
        rd(32'h100);
        wrap_up();
    end
endmodule
